// *** logic/sdrc_pkg.sv ***
`default_nettype none
package sdrc_pkg;
  localparam int CLK_NS = 40;
  localparam int T_RCD_NS = 60;
  localparam int T_RCD_CYC = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RC_NS = 90;
  localparam int T_RC_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] RCD_LOAD = 4'(T_RCD_CYC - 1);
  localparam logic [3:0] RC_LOAD = 4'(T_RC_CYC - 1);
  localparam logic [3:0] RD_LEAD = 4'h2;
  localparam logic [3:0] WR_LEAD = 4'h0;
  localparam logic [3:0] BEATS_M1 = 4'h3;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [2:0] MODE_CL = 3'h3;
  localparam logic MODE_WRAP = 1'h1;
  localparam logic [2:0] MODE_BL = 3'h2;
  localparam logic [7:0] DQM_OFF = 8'hFF;
  localparam int BANK_BIT = 5;
  localparam int COL_LSB = 3;
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam int CTRL_PIPE = 0;
  localparam int CTRL_REF = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  typedef enum logic [3:0] {
    S_IDLE, S_ACT, S_RCD, S_RW, S_LEAD, S_BURST, S_PRE,
    S_CPRE, S_CMRS, S_CDONE, S_REF, S_RWAIT
  } sdrc_bank_st_t;
endpackage
`default_nettype wire

// *** logic/sdrc_bank.sv ***
`default_nettype none
module sdrc_bank
  import sdrc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Requests
  input wire logic start,
  input wire logic is_wr,
  input wire logic is_burst,
  input wire logic cfg_go,
  input wire logic ref_go,
  input wire logic block,
  input wire logic hold,
  input wire logic grant,
  // Status and command request
  output logic [3:0] req,
  output logic take,
  output logic idle,
  output logic in_burst,
  output logic lead_ready,
  output logic rd_active,
  output logic cfg_active,
  output logic cfg_pre,
  output logic cfg_done,
  output logic refreshing,
  output logic [1:0] beat
);
  sdrc_bank_st_t state;
  logic [3:0] cnt;
  logic wr;
  logic burst;

  assign idle = (state == S_IDLE);
  assign take = idle && !cfg_go && !ref_go && start && !block;
  assign in_burst = (state == S_BURST);
  assign lead_ready = (state == S_LEAD) && (cnt == 4'h0);
  assign rd_active = !wr && (state inside {S_RW, S_LEAD, S_BURST});
  assign cfg_active = (state inside {S_CPRE, S_CMRS, S_CDONE});
  assign cfg_pre = (state == S_CPRE);
  assign cfg_done = (state == S_CDONE);
  assign refreshing = (state inside {S_REF, S_RWAIT});
  assign beat = 2'(BEATS_M1 - cnt);

  always_comb begin
    unique case (state)
      S_ACT: req = CMD_ACT;
      S_RW: req = wr ? CMD_WR : CMD_RD;
      S_PRE, S_CPRE: req = CMD_PRE;
      S_CMRS: req = CMD_MRS;
      S_REF: req = CMD_REF;
      default: req = CMD_NOP;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr <= 1'b0;
      burst <= 1'b0;
    end else if (take) begin
      wr <= is_wr;
      burst <= is_burst;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
      cnt <= 4'h0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (cfg_go) state <= S_CPRE;
          else if (ref_go) state <= S_REF;
          else if (take) state <= S_ACT;
        end
        S_ACT: begin
          if (grant) begin
            state <= S_RCD;
            cnt <= RCD_LOAD;
          end
        end
        S_RCD: begin
          if (cnt == 4'h0) state <= S_RW;
          else cnt <= cnt - 4'h1;
        end
        S_RW: begin
          if (grant) begin
            state <= S_LEAD;
            cnt <= wr ? WR_LEAD : RD_LEAD;
          end
        end
        S_LEAD: begin
          if (cnt != 4'h0) cnt <= cnt - 4'h1;
          else if (!hold) begin
            state <= S_BURST;
            cnt <= burst ? BEATS_M1 : 4'h0;
          end
        end
        S_BURST: begin
          // Beats run back to back: no wait state inside a burst
          if (cnt == 4'h0) state <= S_PRE;
          else cnt <= cnt - 4'h1;
        end
        S_PRE: if (grant) state <= S_IDLE;
        S_CPRE: if (grant) state <= S_CMRS;
        S_CMRS: if (grant) state <= S_CDONE;
        S_CDONE: state <= S_IDLE;
        S_REF: begin
          if (grant) begin
            state <= S_RWAIT;
            cnt <= RC_LOAD;
          end
        end
        S_RWAIT: begin
          if (cnt == 4'h0) state <= S_IDLE;
          else cnt <= cnt - 4'h1;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // sdrc_bank
`default_nettype wire

// *** logic/sdrc_top.sv ***
// Added by the designer: the Wishbone register port and the register addresses.
`default_nettype none
module sdrc_top
  import sdrc_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Processor bus
  input wire logic addr_strobe_n,
  input wire logic cpu_write,
  input wire logic cpu_cache_n,
  input wire logic [ADDR_W-1:COL_LSB] cpu_addr,
  input wire logic [7:0] byte_lane_enables,
  input wire logic ext_burst_ready_n_n,
  output logic burst_ready_n,
  output logic next_addr_req_n,
  // Refresh timer
  input wire logic refresh_req_n,
  // SDRAM controls
  output logic sd_cs_n,
  output logic sd_ras_n,
  output logic sd_cas_n,
  output logic sd_we_n,
  output logic [7:0] sd_dqm,
  // Address mux controls
  output logic mux_row,
  output logic mux_all_banks,
  output logic mux_mode,
  output logic mux_bank,
  output logic [1:0] col_seq,
  output logic [6:0] mode_bits,
  // Wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [3:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack
);
  ////////////////////////////////////////////////////////////////////////
  // Decode of the processor cycle
  logic mode_hit;
  logic ads_a;
  logic ads_b;
  logic ads_cfg;
  assign mode_hit = cpu_addr[ADDR_W-1];
  assign ads_cfg = !addr_strobe_n && mode_hit;
  assign ads_a = !addr_strobe_n && !mode_hit && !cpu_addr[BANK_BIT];
  assign ads_b = !addr_strobe_n && !mode_hit && cpu_addr[BANK_BIT];

  // Nine flags
  logic rfrq;
  logic pend_a;
  logic pend_b;
  logic wr_a;
  logic wr_b;
  logic cache_a;
  logic cache_b;
  logic wait_a;
  logic wait_b;
  logic [7:0] be_a;
  logic [7:0] be_b;
  logic [1:0] col_a;
  logic [1:0] col_b;

  // Bank machine wiring
  logic [3:0] req_a;
  logic [3:0] req_b;
  logic take_a;
  logic take_b;
  logic idle_a;
  logic idle_b;
  logic burst_a;
  logic burst_b;
  logic ready_a;
  logic rd_a;
  logic rd_b;
  logic cfg_act;
  logic cfg_pre;
  logic cfg_done;
  logic ref_b;
  logic [1:0] beat_a;
  logic [1:0] beat_b;
  logic grant_a;
  logic grant_b;
  logic cfg_go;
  logic ref_go;

  // Configuration and refresh bookkeeping
  logic cfg_need;
  logic cfg_cpu;
  logic configured;
  logic rf_s1;
  logic rf_s2;

  // Registers
  logic [1:0] ctrl;
  logic sw_ref;

  // Registered outputs, and next_cmd that feeds sd_cmd
  logic [3:0] sd_cmd;
  logic [3:0] next_cmd;
  logic burst_ready_n_q;
  logic na_q;

  ////////////////////////////////////////////////////////////////////////
  // Access latches: a new strobe may arrive while a bank is busy
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_a <= 1'b0;
      pend_b <= 1'b0;
    end else begin
      if (ads_a) pend_a <= 1'b1;
      else if (take_a) pend_a <= 1'b0;
      if (ads_b) pend_b <= 1'b1;
      else if (take_b) pend_b <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_a <= 1'b0;
      cache_a <= 1'b0;
      be_a <= 8'h00;
      col_a <= 2'h0;
    end else if (ads_a) begin
      wr_a <= cpu_write;
      cache_a <= !cpu_cache_n;
      be_a <= byte_lane_enables;
      col_a <= cpu_addr[COL_LSB+1:COL_LSB];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_b <= 1'b0;
      cache_b <= 1'b0;
      be_b <= 8'h00;
      col_b <= 2'h0;
    end else if (ads_b) begin
      wr_b <= cpu_write;
      cache_b <= !cpu_cache_n;
      be_b <= byte_lane_enables;
      col_b <= cpu_addr[COL_LSB+1:COL_LSB];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_a <= 1'b0;
      wait_b <= 1'b0;
    end else begin
      wait_a <= burst_a;
      wait_b <= burst_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Refresh: latch, then two-stage synchroniser before bank B sees it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rfrq <= 1'b0;
      rf_s1 <= 1'b0;
      rf_s2 <= 1'b0;
    end else begin
      if (!refresh_req_n || sw_ref) rfrq <= 1'b1;
      else if (ref_go && idle_b) rfrq <= 1'b0;
      rf_s1 <= rfrq;
      rf_s2 <= rf_s1;
    end
  end

  // Refresh covers both banks, so bank A must stand idle
  assign ref_go = rf_s2 && configured && idle_a && !cfg_go;

  ////////////////////////////////////////////////////////////////////////
  // Configuration: due after reset, or on a processor hit to mode space
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_need <= 1'b1;
      cfg_cpu <= 1'b0;
      configured <= 1'b0;
    end else begin
      if (cfg_done) cfg_need <= 1'b0;
      if (ads_cfg) cfg_cpu <= 1'b1;
      else if (cfg_done) cfg_cpu <= 1'b0;
      if (cfg_done) configured <= 1'b1;
    end
  end

  assign cfg_go = (cfg_need || cfg_cpu) && idle_b && !ref_b;

  ////////////////////////////////////////////////////////////////////////
  // Two bank machines sharing one command bus; bank A has priority
  assign grant_a = (req_a != CMD_NOP);
  assign grant_b = (req_b != CMD_NOP) && !grant_a;

  sdrc_bank u_bank_a (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .start(pend_a && configured),
    .is_wr(wr_a),
    .is_burst(cache_a),
    .cfg_go(cfg_go),
    .ref_go(1'b0),
    .block(ref_b || ref_go),
    .hold(burst_b && beat_b != 2'h3),
    .grant(grant_a),
    .req(req_a),
    .take(take_a),
    .idle(idle_a),
    .in_burst(burst_a),
    .lead_ready(ready_a),
    .rd_active(rd_a),
    .cfg_active(cfg_act),
    .cfg_pre(cfg_pre),
    .cfg_done(cfg_done),
    .refreshing(),
    .beat(beat_a)
  );

  sdrc_bank u_bank_b (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .start(pend_b && configured),
    .is_wr(wr_b),
    .is_burst(cache_b),
    .cfg_go(1'b0),
    .ref_go(ref_go),
    .block(cfg_act || cfg_go),
    .hold((burst_a && beat_a != 2'h3) || ready_a), // Last beat hands over
    .grant(grant_b),
    .req(req_b),
    .take(take_b),
    .idle(idle_b),
    .in_burst(burst_b),
    .lead_ready(),
    .rd_active(rd_b),
    .cfg_active(),
    .cfg_pre(),
    .cfg_done(),
    .refreshing(ref_b),
    .beat(beat_b)
  );

  ////////////////////////////////////////////////////////////////////////
  // Shared registered output decoder; clock enable is left to the board
  assign next_cmd = grant_a ? req_a : req_b;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sd_cmd <= CMD_NOP;
      mux_row <= 1'b0;
      mux_all_banks <= 1'b0;
      mux_mode <= 1'b0;
      mux_bank <= 1'b0;
    end else begin
      sd_cmd <= next_cmd;
      mux_row <= (next_cmd == CMD_ACT);
      mux_all_banks <= grant_a && cfg_pre;
      mux_mode <= (next_cmd == CMD_MRS);
      mux_bank <= grant_b;
    end
  end

  assign sd_cs_n = sd_cmd[3];
  assign sd_ras_n = sd_cmd[2];
  assign sd_cas_n = sd_cmd[1];
  assign sd_we_n = sd_cmd[0];
  assign mode_bits = mux_mode ? {MODE_CL, MODE_WRAP, MODE_BL} : 7'h00;

  // Masks: open while either bank reads, otherwise byte lanes for single writes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sd_dqm <= DQM_OFF;
    end else if (rd_a || rd_b) begin
      sd_dqm <= 8'h00;
    end else if (next_cmd == CMD_WR) begin
      if (grant_a) sd_dqm <= cache_a ? 8'h00 : ~be_a;
      else sd_dqm <= cache_b ? 8'h00 : ~be_b;
    end else begin
      sd_dqm <= DQM_OFF;
    end
  end

  // Later burst addresses: opening column XOR beat gives interleaved wrap
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      col_seq <= 2'h0;
    end else if (burst_a) begin
      col_seq <= col_a ^ beat_a;
    end else if (burst_b) begin
      col_seq <= col_b ^ beat_b;
    end
  end

  // Terminations; next-address pulses on a burst's first beat
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      burst_ready_n_q <= 1'b0;
      na_q <= 1'b0;
    end else begin
      burst_ready_n_q <= burst_a || burst_b || (cfg_done && cfg_cpu);
      na_q <= ctrl[CTRL_PIPE] && ((burst_a && beat_a == 2'h0) ||
                                  (burst_b && beat_b == 2'h0));
    end
  end

  // Other sources join ours here; any low input ends the transfer
  assign burst_ready_n = !burst_ready_n_q && ext_burst_ready_n_n;
  assign next_addr_req_n = !na_q;

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave, one wait state, unmapped reads return zero
  logic wb_hit;
  assign wb_hit = wb_cyc && wb_stb;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
    end else begin
      wb_ack <= wb_hit && !wb_ack;
      if (wb_adr[3:2] == REG_CTRL) wb_dat_r <= {30'h0, 1'b0, ctrl[CTRL_PIPE]};
      else if (wb_adr[3:2] == REG_STAT)
        wb_dat_r <= {28'h0, rfrq, !idle_b, !idle_a, configured};
      else wb_dat_r <= 32'h0000_0000;
    end
  end

  // Write lands on the edge where the master sees ack
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= CTRL_RESET;
      sw_ref <= 1'b0;
    end else begin
      sw_ref <= 1'b0;
      if (wb_hit && wb_ack && wb_we && wb_sel[0] && wb_adr[3:2] == REG_CTRL) begin
        ctrl[CTRL_PIPE] <= wb_dat_w[CTRL_PIPE];
        sw_ref <= wb_dat_w[CTRL_REF];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_mode_load;
    (sd_cmd == CMD_MRS) && !mux_all_banks;
  endsequence

  sequence s_four_beats;
    burst_a [*4] ##1 !burst_a;
  endsequence

  chk_mrs_single: assert property (
    s_mode_load |=> sd_cmd == CMD_NOP)
    else $error("mode load command held more than one clock");

  chk_cfg_order: assert property (
    s_mode_load |-> $past(sd_cmd) == CMD_PRE && $past(mux_all_banks))
    else $error("mode load not preceded by precharge of all banks");

  chk_cfg_first: assert property (
    !configured |-> sd_cmd != CMD_ACT && sd_cmd != CMD_RD && sd_cmd != CMD_WR)
    else $error("access issued before mode register load");

  chk_cfg_burst_ready_n: assert property (
    (sd_cmd == CMD_MRS && cfg_cpu) |=> burst_ready_n_q)
    else $error("no burst ready after configuration cycle");

  chk_burst_beats: assert property (
    ($rose(burst_a) && cache_a) |-> s_four_beats)
    else $error("burst of bank A not four back-to-back beats");

  chk_wrap_order: assert property (
    $rose(burst_a) && cache_a |=> ##3 col_seq == (col_a ^ 2'h3))
    else $error("fourth burst address not in interleaved order");

  chk_na_in_burst: assert property (
    na_q |-> (wait_a || wait_b) && ctrl[CTRL_PIPE])
    else $error("next address given outside a burst");

  chk_dqm_read: assert property (
    sd_cmd == CMD_RD |-> sd_dqm == 8'h00)
    else $error("data masks not open during read");

  chk_one_burst: assert property (
    !(burst_a && burst_b))
    else $error("both banks bursting at once");

  chk_ref_first: assert property (
    (ref_go && idle_b && pend_b) |=> ref_b)
    else $error("access served before pending refresh");

endmodule // sdrc_top
`default_nettype wire

// *** tb/sdrc_sdram_model.sv ***
`default_nettype none
module sdrc_sdram_model
  import sdrc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Command and mask pins
  input wire logic sd_cs_n,
  input wire logic sd_ras_n,
  input wire logic sd_cas_n,
  input wire logic sd_we_n,
  input wire logic [7:0] sd_dqm,
  // Registered address mux controls
  input wire logic mux_all_banks,
  input wire logic mux_mode,
  input wire logic [6:0] mode_bits
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////
  logic [3:0] cmd;
  logic configured = 1'h0;
  logic pre_all = 1'h0;
  logic [6:0] mode_word = 7'h00;
  logic [3:0] cmd_q[$];
  logic [7:0] dqm_q[$];
  int cyc_q[$];
  int cyc = 0;
  int early_count = 0;

  assign cmd = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};

  // Pins are looked at on rising edges only, never in between
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (arst_n && cmd !== CMD_NOP) begin
      cmd_q.push_back(cmd);
      dqm_q.push_back(sd_dqm);
      cyc_q.push_back(cyc);
    end
    // A10 comes from the external mux, so the all-banks control stands for it
    if (cmd === CMD_PRE && mux_all_banks === 1'h1) begin
      pre_all <= 1'h1;
    end
    if (cmd === CMD_MRS && mux_mode === 1'h1) begin
      configured <= 1'h1;
      mode_word <= mode_bits;
    end
    // Real parts give garbage when used unconfigured, so count it as a fault
    if ((cmd === CMD_RD || cmd === CMD_WR) && !configured) begin
      early_count <= early_count + 1;
    end
  end
endmodule // sdrc_sdram_model
`default_nettype wire

// *** tb/tb_sdrc_top.sv ***
`default_nettype none
module tb_sdrc_top
  import sdrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////
  logic core_clk = 1'h0;
  logic arst_n = 1'h0;
  logic addr_strobe_n = 1'h1;
  logic cpu_write = 1'h0;
  logic cpu_cache_n = 1'h1;
  logic [31:3] cpu_addr = 29'h0;
  logic [7:0] byte_lane_enables = 8'h00;
  logic ext_burst_ready_n_n = 1'h1;
  logic refresh_req_n = 1'h1;
  logic wb_cyc = 1'h0;
  logic wb_stb = 1'h0;
  logic wb_we = 1'h0;
  logic [3:0] wb_adr = 4'h0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0;
  logic burst_ready_n, next_addr_req_n, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n;
  logic mux_row, mux_all_banks, mux_mode, mux_bank, wb_ack;
  logic [7:0] sd_dqm;
  logic [1:0] col_seq;
  logic [6:0] mode_bits;
  logic [31:0] wb_dat_r, d;
  int cyc = 0;
  int bad_count = 0;
  int check_count = 0;
  int burst_ready_n_q[$], na_q[$], t0, t1;
  logic [1:0] col_q[$], act_q[$];

  sdrc_top sdrc_top_i (.core_clk(core_clk), .arst_n(arst_n), .addr_strobe_n(addr_strobe_n),
    .cpu_write(cpu_write), .cpu_cache_n(cpu_cache_n), .cpu_addr(cpu_addr),
    .byte_lane_enables(byte_lane_enables), .ext_burst_ready_n_n(ext_burst_ready_n_n),
    .burst_ready_n(burst_ready_n), .next_addr_req_n(next_addr_req_n),
    .refresh_req_n(refresh_req_n), .sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n),
    .sd_cas_n(sd_cas_n), .sd_we_n(sd_we_n), .sd_dqm(sd_dqm), .mux_row(mux_row),
    .mux_all_banks(mux_all_banks), .mux_mode(mux_mode), .mux_bank(mux_bank),
    .col_seq(col_seq), .mode_bits(mode_bits), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));

  sdrc_sdram_model sdrc_sdram_model_i (.core_clk(core_clk), .arst_n(arst_n),
    .sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n), .sd_we_n(sd_we_n),
    .sd_dqm(sd_dqm), .mux_all_banks(mux_all_banks), .mux_mode(mux_mode),
    .mode_bits(mode_bits));

  always #20 core_clk = ~core_clk;

  // Column and burst-ready leave the same register edge, so they are taken together
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (burst_ready_n === 1'h0) burst_ready_n_q.push_back(cyc);
    if (burst_ready_n === 1'h0) col_q.push_back(col_seq);
    if ({sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} === CMD_ACT)
      act_q.push_back({mux_row, mux_bank});
    if (next_addr_req_n === 1'h0) na_q.push_back(cyc);
    if (cyc == 4000) begin
      bad_count++;
      final_report();
    end
  end
  ////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge core_clk);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hF;
    wb_dat_w <= wd;
    do @(posedge core_clk); while (wb_ack !== 1'h1);
    rd = wb_dat_r;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
  endtask

  task automatic clr();
    burst_ready_n_q.delete();
    col_q.delete();
    na_q.delete();
    act_q.delete();
    sdrc_sdram_model_i.cmd_q.delete();
    sdrc_sdram_model_i.dqm_q.delete();
    sdrc_sdram_model_i.cyc_q.delete();
  endtask

  task automatic go(input logic [31:3] a, input logic w, input logic c_n,
      input logic [7:0] be, output int t);
    @(posedge core_clk);
    addr_strobe_n <= 1'h0;
    cpu_addr <= a;
    cpu_write <= w;
    cpu_cache_n <= c_n;
    byte_lane_enables <= be;
    @(posedge core_clk);
    t = cyc;
    addr_strobe_n <= 1'h1;
  endtask

  // Wait for the beats, then until both banks report idle
  task automatic done(input int k);
    logic [31:0] s;
    while (burst_ready_n_q.size() < k) @(posedge core_clk);
    do wb(1'h0, 4'h4, 32'h0, s); while (s[2:1] !== 2'h0);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'h1;
    do wb(1'h0, 4'h4, 32'h0, d); while (d[0] !== 1'h1);
    chk("cfg pre", CMD_PRE, sdrc_sdram_model_i.cmd_q[0]);
    chk("cfg mrs", CMD_MRS, sdrc_sdram_model_i.cmd_q[1]);
    chk("cfg a10", 32'h1, sdrc_sdram_model_i.pre_all);
    chk("mode word", 32'h3A, sdrc_sdram_model_i.mode_word);
    chk("auto burst_ready_n", 32'h0, burst_ready_n_q.size());
    wb(1'h0, 4'h0, 32'h0, d);
    chk("ctrl reset", 32'h1, d);
    wb(1'h1, 4'h8, 32'hFFFFFFFF, d);
    wb(1'h0, 4'h8, 32'h0, d);
    chk("unmapped", 32'h0, d);
    // Opening column 1 on bank A, cacheable read
    clr();
    go(29'h1, 1'h0, 1'h0, 8'hFF, t0);
    done(4);
    for (int i = 0; i < 4; i++) chk("rd beat", t0 + 10 + i, burst_ready_n_q[i]);
    for (int i = 0; i < 4; i++) chk("rd col", 1 ^ i, col_q[i]);
    chk("rd beats", 32'h4, burst_ready_n_q.size());
    chk("rd act", CMD_ACT, sdrc_sdram_model_i.cmd_q[0]);
    chk("rd row bank", 32'h2, act_q[0]);
    chk("rd cmd", CMD_RD, sdrc_sdram_model_i.cmd_q[1]);
    chk("act at", t0 + 3, sdrc_sdram_model_i.cyc_q[0]);
    chk("rd at", t0 + 6, sdrc_sdram_model_i.cyc_q[1]);
    chk("rd dqm", 32'h0, sdrc_sdram_model_i.dqm_q[1]);
    chk("na pulse", t0 + 10, na_q[0]);
    // Pipelining off: single masked write to bank B, no next-address
    wb(1'h1, 4'h0, 32'h0, d);
    clr();
    go(29'h4, 1'h1, 1'h1, 8'h5A, t0);
    done(1);
    chk("wr beat", t0 + 8, burst_ready_n_q[0]);
    chk("wr beats", 32'h1, burst_ready_n_q.size());
    chk("wr cmd", CMD_WR, sdrc_sdram_model_i.cmd_q[1]);
    chk("wr row bank", 32'h3, act_q[0]);
    chk("wr dqm", 32'hA5, sdrc_sdram_model_i.dqm_q[1]);
    chk("na off", 32'h0, na_q.size());
    wb(1'h1, 4'h0, 32'h1, d);
    // Back-to-back bursts to alternate banks
    clr();
    go(29'h0, 1'h0, 1'h0, 8'hFF, t0);
    go(29'h6, 1'h0, 1'h0, 8'hFF, t1);
    done(8);
    for (int i = 0; i < 8; i++) chk("pipe beat", burst_ready_n_q[0] + i, burst_ready_n_q[i]);
    for (int i = 0; i < 4; i++) chk("pipe col", 2 ^ i, col_q[4 + i]);
    // Refresh latched together with a pending bank B access
    clr();
    refresh_req_n <= 1'h0;
    // Strobe lands as the synchronised refresh reaches bank B
    @(posedge core_clk);
    go(29'h4, 1'h0, 1'h0, 8'hFF, t0);
    refresh_req_n <= 1'h1;
    done(4);
    chk("ref first", CMD_REF, sdrc_sdram_model_i.cmd_q[0]);
    chk("then act", CMD_ACT, sdrc_sdram_model_i.cmd_q[1]);
    // Processor access to the mode register space
    clr();
    go(29'h10000000, 1'h0, 1'h1, 8'hFF, t0);
    done(1);
    chk("cfg2 pre", CMD_PRE, sdrc_sdram_model_i.cmd_q[0]);
    chk("cfg2 mrs", CMD_MRS, sdrc_sdram_model_i.cmd_q[1]);
    chk("cfg2 burst_ready_n", sdrc_sdram_model_i.cyc_q[1] + 1, burst_ready_n_q[0]);
    // Another burst-ready source passes straight through
    clr();
    @(posedge core_clk);
    ext_burst_ready_n_n <= 1'h0;
    @(posedge core_clk);
    t0 = cyc;
    ext_burst_ready_n_n <= 1'h1;
    @(posedge core_clk);
    chk("merged burst_ready_n", t0, burst_ready_n_q[0]);
    chk("merged once", 32'h1, burst_ready_n_q.size());
    chk("early access", 32'h0, sdrc_sdram_model_i.early_count);
    final_report();
  end
endmodule // tb_sdrc_top
`default_nettype wire
